// ==== pkg/i2c_mem_map.vh ====
// Function
// - The array holds 16,384 locations of eight bits each, reached only over the serial link.
// - Each data byte received while write-protect is low passes a two-entry buffer and reaches the array a few clock cycles after its transfer ends.
// - The part answers only when the three select bits of the slave address equal its select pins.
// - Outgoing bits change after a falling serial clock edge and incoming bits are taken on a rising edge.
// - A high write-protect input blocks writes to every address; low leaves all writable.
// - The data line is only ever pulled low or released, never driven high.
// - A read-only identification value names maker, density and revision and no write changes it.
// - The link works at 100 kHz, 400 kHz and up to the 3.4 MHz high-speed rate.
// - Any number of reads and writes run back to back with no erase or programming phase.
// - The first byte after a start holds type code 1010b, three select bits and a read bit at bit 0.
// - A write sends two address bytes and only the low 14 address bits are kept.
// - The address latch steps after each data byte before the acknowledge and wraps 3FFFh to 0000h.
// - The master code 00001XXXb enters high-speed operation and a stop leaves it.
`ifndef I2C_MEM_MAP_VH
`define I2C_MEM_MAP_VH

// Array shape
`define ADDR_W        14
`define MEM_DEPTH     16384
`define DATA_W        8

// First byte layout
`define SLAVE_TYPE    4'ha
`define HS_CODE       5'h01
`define RW_BIT        0

// Clock figures in ns and derived cycles per high-speed serial clock period
`define CLK_PERIOD_NS    10
`define SCL_HS_PERIOD_NS 294
`define SCL_HS_CYCLES    (`SCL_HS_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ==== rtl/two_entry_buffer.v ====
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer #(
	parameter W = 22
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] slot0_q;
	reg [W-1:0] slot1_q;
	reg         rd_ptr_q;
	reg         wr_ptr_q;
	reg [1:0]   count_q;
	wire        push;
	wire        pop;

	// Handshakes on both sides
	assign in_ready  = (count_q != 2'd2);
	assign out_valid = (count_q != 2'd0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = rd_ptr_q ? slot1_q : slot0_q;

	// Entry storage
	always @(posedge clk) begin
		if (push & ~wr_ptr_q)
			slot0_q <= in_data;
		if (push & wr_ptr_q)
			slot1_q <= in_data;
	end

	// Pointers and fill count
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_ptr_q <= 1'b0;
			wr_ptr_q <= 1'b0;
			count_q  <= 2'd0;
		end else begin
			if (push)
				wr_ptr_q <= ~wr_ptr_q;
			if (pop)
				rd_ptr_q <= ~rd_ptr_q;
			case ({push, pop})
				2'b10:   count_q <= count_q + 2'd1;
				2'b01:   count_q <= count_q - 2'd1;
				default: count_q <= count_q;
			endcase
		end
	end
endmodule // two_entry_buffer
`default_nettype wire

// ==== rtl/i2c_mem_slave.v ====
`timescale 1ns/10ps
`default_nettype none
`include "i2c_mem_map.vh"
module i2c_mem_slave #(
	parameter [23:0] ID_VALUE = 24'h5a3c01  // Arbitrary identification value
) (
	input  wire        clk,
	input  wire        rst_b,
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe,
	input  wire [2:0]  device_select_pins,
	input  wire        write_protect,
	output reg         hs_mode,
	output reg  [23:0] id_value
);
	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_DEV  = 3'd1;
	localparam [2:0] ST_AHI  = 3'd2;
	localparam [2:0] ST_ALO  = 3'd3;
	localparam [2:0] ST_WR   = 3'd4;
	localparam [2:0] ST_RD   = 3'd5;
	localparam       BW      = `ADDR_W + `DATA_W;

	reg  [`DATA_W-1:0] mem [0:`MEM_DEPTH-1];
	reg                scl_s1_q, scl_s2_q, scl_s3_q;
	reg                sda_s1_q, sda_s2_q, sda_s3_q;
	reg  [2:0]         sel_s1_q, sel_s2_q;
	reg                wp_s1_q, wp_s2_q;
	reg  [2:0]         state_q;
	reg  [7:0]         shift_q;
	reg  [7:0]         tx_q;
	reg  [2:0]         bit_cnt_q;
	reg  [`ADDR_W-1:0] addr_q;
	reg                slot_q;
	reg                own_q;
	reg                drive_ack_q;
	reg                end_slot_q;
	reg                fetch_q;
	reg  [7:0]         rd_data_q;
	wire               scl_rise, scl_fall, start_det, stop_det;
	wire [7:0]         byte_in;
	wire               byte_done;
	wire               dev_match;
	wire               push, buf_ready;
	wire               buf_valid, mem_we;
	wire [BW-1:0]      buf_data;

	// Two-flop synchronisers, third stage only for edge finding
	// rate-independent oversampling
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
			sel_s1_q <= 3'h0;
			sel_s2_q <= 3'h0;
			wp_s1_q  <= 1'b0;
			wp_s2_q  <= 1'b0;
		end else begin
			scl_s1_q <= scl_in;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= sda_in;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
			sel_s1_q <= device_select_pins;
			sel_s2_q <= sel_s1_q;
			wp_s1_q  <= write_protect;
			wp_s2_q  <= wp_s1_q;
		end
	end

	// Bus events
	assign scl_rise  = scl_s2_q & ~scl_s3_q;
	assign scl_fall  = ~scl_s2_q & scl_s3_q;
	assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
	assign stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
	assign byte_in   = {shift_q[6:0], sda_s2_q};
	assign byte_done = scl_rise & ~slot_q & (bit_cnt_q == 3'd7) & (state_q != ST_IDLE);
	assign dev_match = (byte_in[7:4] == `SLAVE_TYPE) & (byte_in[3:1] == sel_s2_q);
	assign push      = byte_done & (state_q == ST_WR) & ~wp_s2_q;

	// Serial protocol engine
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q     <= ST_IDLE;
			shift_q     <= 8'h00;
			tx_q        <= 8'h00;
			bit_cnt_q   <= 3'd0;
			addr_q      <= {`ADDR_W{1'b0}};
			slot_q      <= 1'b0;
			own_q       <= 1'b0;
			drive_ack_q <= 1'b0;
			end_slot_q  <= 1'b0;
			fetch_q     <= 1'b0;
			sda_oe      <= 1'b0;
			hs_mode     <= 1'b0;
		end else begin
			fetch_q <= 1'b0;
			if (start_det) begin
				state_q     <= ST_DEV;
				bit_cnt_q   <= 3'd0;
				slot_q      <= 1'b0;
				own_q       <= 1'b0;
				drive_ack_q <= 1'b0;
				end_slot_q  <= 1'b0;
				sda_oe      <= 1'b0;
			end else if (stop_det) begin
				state_q     <= ST_IDLE;
				hs_mode     <= 1'b0;
				slot_q      <= 1'b0;
				own_q       <= 1'b0;
				drive_ack_q <= 1'b0;
				end_slot_q  <= 1'b0;
				sda_oe      <= 1'b0;
			end else if (scl_rise && state_q != ST_IDLE) begin
				if (slot_q) begin
					slot_q     <= 1'b0;
					end_slot_q <= 1'b1;
					if (state_q == ST_RD && !own_q) begin
						if (sda_s2_q)
							state_q <= ST_IDLE;  // Master ended the read
						else
							fetch_q <= 1'b1;
					end
				end else begin
					shift_q   <= byte_in;
					bit_cnt_q <= bit_cnt_q + 3'd1;
					if (bit_cnt_q == 3'd7) begin
						slot_q <= 1'b1;
						own_q  <= (state_q != ST_RD);
						case (state_q)
							ST_DEV: begin
								if (byte_in[7:3] == `HS_CODE) begin
									hs_mode <= 1'b1;
									state_q <= ST_IDLE;
								end else if (dev_match) begin
									drive_ack_q <= 1'b1;
									if (byte_in[`RW_BIT]) begin
										state_q <= ST_RD;
										fetch_q <= 1'b1;
									end else begin
										state_q <= ST_AHI;
									end
								end else begin
									state_q <= ST_IDLE;
								end
							end
							ST_AHI: begin
								addr_q[`ADDR_W-1:8] <= byte_in[`ADDR_W-9:0];
								drive_ack_q         <= 1'b1;
								state_q             <= ST_ALO;
							end
							ST_ALO: begin
								addr_q[7:0] <= byte_in;
								drive_ack_q <= 1'b1;
								state_q     <= ST_WR;
							end
							ST_WR: begin
								// ack and step even when protected
								if (buf_ready || wp_s2_q) begin
									drive_ack_q <= 1'b1;
									addr_q      <= addr_q + {{(`ADDR_W-1){1'b0}}, 1'b1};
								end else begin
									state_q <= ST_IDLE;
								end
							end
							ST_RD: begin
								addr_q <= addr_q + {{(`ADDR_W-1){1'b0}}, 1'b1};
							end
							default: state_q <= ST_IDLE;
						endcase
					end
				end
			end else if (scl_fall) begin
				// drive only low, after falling edge
				if (drive_ack_q) begin
					drive_ack_q <= 1'b0;
					sda_oe      <= 1'b1;
				end else if (end_slot_q) begin
					end_slot_q <= 1'b0;
					own_q      <= 1'b0;
					if (state_q == ST_RD) begin
						tx_q   <= rd_data_q;
						sda_oe <= ~rd_data_q[7];
					end else begin
						sda_oe <= 1'b0;
					end
				end else if (state_q == ST_RD && !slot_q) begin
					tx_q   <= {tx_q[6:0], 1'b0};
					sda_oe <= ~tx_q[6];
				end else begin
					sda_oe <= 1'b0;  // Release for the master's ack
				end
			end
		end
	end

	// bytes wait at most a few cycles before the array
	two_entry_buffer #(
		.W (BW)
	) u_wbuf (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (push),
		.in_ready  (buf_ready),
		.in_data   ({addr_q, byte_in}),
		.out_valid (buf_valid),
		.out_ready (mem_we),
		.out_data  (buf_data)
	);

	// Read fetch takes the single array port first
	assign mem_we = buf_valid & ~fetch_q;

	always @(posedge clk) begin
		if (mem_we)
			mem[buf_data[BW-1:`DATA_W]] <= buf_data[`DATA_W-1:0];
	end

	// Read data register
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			rd_data_q <= 8'h00;
		else if (fetch_q)
			rd_data_q <= mem[addr_q];
	end

	// constant low drive level and fixed identification
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sda_out  <= 1'b0;
			id_value <= ID_VALUE;
		end else begin
			sda_out  <= 1'b0;
			id_value <= ID_VALUE;
		end
	end
endmodule // i2c_mem_slave
`default_nettype wire

// ==== tb/i2c_mem_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2c_mem_props #(
	parameter [23:0] ID_VALUE = 24'h5a3c01  // Arbitrary identification value
) (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic [2:0]  device_select_pins,
	input wire logic        write_protect,
	input wire logic        hs_mode,
	input wire logic [23:0] id_value
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Line and mode relations
	property p_drain; sda_oe |-> sda_out == 1'b0; endproperty
	property p_release; sda_oe |-> ##[1:200] !sda_oe; endproperty
	property p_edge; $changed(sda_oe) |-> !$past(scl_in, 2); endproperty
	property p_stand; $changed(sda_oe) |=> $stable(sda_oe) [*6]; endproperty
	property p_hs_exit; scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:6] !hs_mode; endproperty
	property p_hs_noack; $rose(hs_mode) |-> !sda_oe [*8]; endproperty
	property p_id; id_value == ID_VALUE; endproperty
	property p_rst; disable iff (1'b0) !rst_b |-> !sda_oe && !hs_mode && id_value == ID_VALUE; endproperty
	a_drain: assert property (p_drain) else $error("data line driven high");
	a_release: assert property (p_release) else $error("data line held too long");
	a_edge: assert property (p_edge) else $error("data changed away from clock low");
	a_stand: assert property (p_stand) else $error("data bit too short");
	a_hs_exit: assert property (p_hs_exit) else $error("fast mode kept after stop");
	a_hs_noack: assert property (p_hs_noack) else $error("master code answered");
	a_id: assert property (p_id) else $error("identification changed");
	a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
	c_ack: cover property ($rose(sda_oe));
	c_hs: cover property ($rose(hs_mode));
	c_wp: cover property (write_protect && $rose(sda_oe));
endmodule // i2c_mem_props
bind i2c_mem_slave i2c_mem_props #(.ID_VALUE(ID_VALUE)) u_props (.clk(clk), .rst_b(rst_b), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .device_select_pins(device_select_pins),
	.write_protect(write_protect), .hs_mode(hs_mode), .id_value(id_value));
`default_nettype wire

// ==== tb/i2c_master_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda
);
	// Bus idle, both lines released
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// one bit, 80 ns, data moves mid low phase
	task automatic bit_io(input logic b, output logic s);
		scl = 1'b0;
		#20 sda_m = b;
		#20 scl = 1'b1;
		#20 s = sda;
		#20;
	endtask
	task automatic start;
		scl = 1'b0;
		#20 sda_m = 1'b1;
		#20 scl = 1'b1;
		#20 sda_m = 1'b0;
		#20;
	endtask
	task automatic stop;
		scl = 1'b0;
		#20 sda_m = 1'b0;
		#20 scl = 1'b1;
		#20 sda_m = 1'b1;
		#20;
	endtask
	task automatic put(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask
	// Byte in, last one refused
	task automatic get(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, s);
	endtask
endmodule // i2c_master_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0, rst_b = 1'b1, wp = 1'b0, sda_out, sda_oe, hs_mode, scl, sda_m, ack;
	logic [2:0]  sel = 3'h0;
	logic [23:0] id;
	logic [7:0]  ref_mem [int];
	int          failures = 0, checks = 0;
	wire         sda_w = sda_m & ~sda_oe;
	always #5 clk = ~clk;
	i2c_master_model m (.scl(scl), .sda_m(sda_m), .sda(sda_w));
	i2c_mem_slave DUT (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .device_select_pins(sel), .write_protect(wp), .hs_mode(hs_mode), .id_value(id));
	function automatic logic [15:0] nxt(input logic [15:0] a);
		return {2'b00, a[13:0] + 14'h1};
	endfunction
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Start, select byte, two address bytes
	task automatic addr(input logic [2:0] s, input logic [15:0] a);
		m.start;
		m.put({4'ha, s, 1'b0}, ack);
		check("select ack", s == sel, ack);
		m.put(a[15:8], ack);
		check("addr hi ack", s == sel, ack);
		m.put(a[7:0], ack);
		check("addr lo ack", s == sel, ack);
	endtask
	task automatic wr(input logic [15:0] a, input int n);
		logic [7:0] d;
		addr(sel, a);
		repeat (n) begin
			d = $urandom;
			m.put(d, ack);
			check("data ack", 1'b1, ack);
			if (!wp) ref_mem[a[13:0]] = d;
			a = nxt(a);
		end
		m.stop;
	endtask
	task automatic rd(input logic [15:0] a, input int n);
		logic [7:0] d;
		addr(sel, a);
		m.start;
		m.put({4'ha, sel, 1'b1}, ack);
		check("read select ack", 1'b1, ack);
		for (int i = 1; i <= n; i++) begin
			m.get(i == n, d);
			if (ref_mem.exists(a[13:0])) check("read", ref_mem[a[13:0]], d);
			a = nxt(a);
		end
		m.stop;
	endtask
	// Main sequence
	initial begin
		// Falling reset edge so the first clock already sees reset values
		#1 rst_b = 1'b0;
		void'($urandom(12675));
		repeat (12) @(posedge clk);
		@(negedge clk) rst_b = 1'b1;
		repeat (4) @(negedge clk);
		check("id", 24'h5a3c01, id);
		check("drive level", 1'b0, sda_out);
		repeat (6) begin : burst
			logic [15:0] a;
			int n;
			a = $urandom;
			n = $urandom_range(1, 4);
			@(negedge clk) sel = $urandom;
			wr(a, n);
			rd(a, n);
		end
		wr(16'hfffe, 4);
		rd(16'h3ffe, 4);
		$display("test burst done");
		@(negedge clk) wp = 1'b1;
		wr(16'h3ffe, 2);
		@(negedge clk) wp = 1'b0;
		rd(16'h3ffe, 2);
		$display("test protect done");
		for (int s = 0; s < 8; s++) begin
			addr(s[2:0], 16'h0000);
			m.stop;
		end
		$display("test select done");
		m.start;
		m.put(8'h0b, ack);
		check("code ack", 1'b0, ack);
		repeat (5) @(negedge clk);
		check("fast on", 1'b1, hs_mode);
		wr(16'h0123, 2);
		repeat (8) @(negedge clk);
		check("fast off", 1'b0, hs_mode);
		rd(16'h0123, 2);
		// Mid-run reset with high speed set, array must survive
		m.start;
		m.put(8'h0b, ack);
		@(negedge clk);
		check("fast again", 1'b1, hs_mode);
		rst_b = 1'b0;
		repeat (3) @(negedge clk);
		check("reset fast", 1'b0, hs_mode);
		check("reset drive", 1'b0, sda_oe);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		rd(16'h0123, 2);
		$display("test fast done");
		results;
	end
	// Watchdog, about four times the expected run
	initial begin
		#400000;
		failures++;
		results;
	end
endmodule // tb_top
`default_nettype wire
